// >>> hw/spicfg_core.sv
/*
 * spicfg_core: SPI configuration/status register with its shift engine.
 * Assumes a byte register port (address, write and read strobes), a transmit
 * byte offered by the surrounding unit, and pins from another clock domain.
 */
`timescale 1ns/100ps
module spicfg_core
	import spicfg_pkg::*;
(
	input  wire logic       clk,          // 20 MHz system clock
	input  wire logic       reset,        // synchronous, active high
	input  wire logic [7:0] reg_addr,     // register address
	input  wire logic       reg_wr,       // write strobe
	input  wire logic       reg_rd,       // read strobe
	input  wire logic [7:0] reg_wdata,    // write data
	output logic      [7:0] reg_rdata,    // read data, valid next cycle
	input  wire logic       tx_valid,     // new transmit byte present
	input  wire logic [7:0] tx_data,      // transmit byte
	output logic            tx_taken,     // pulse: byte loaded to shifter
	output logic      [7:0] rx_data,      // received byte
	input  wire logic       rx_read,      // pulse: rx buffer read
	output logic            rx_new,       // pulse: byte received
	input  wire logic       sck_in,       // serial clock pin input
	output logic            sck_out,      // serial clock pin output
	output logic            sck_oe_n,     // low while driving clock
	input  wire logic       mosi_in,      // data from master
	output logic            mosi_out,     // data to slave
	input  wire logic       miso_in,      // data from slave
	output logic            miso_out,     // data to master
	input  wire logic       slave_select_pin  // active low select
);
	typedef enum logic [1:0] {SC_IDLE, SC_FIRST, SC_SECOND} spicfg_state_t;

	logic          master_select_bit, clock_phase_bit, clock_polarity_bit;
	logic          transfer_busy_flag, shifter_empty_flag, rx_buffer_empty_flag;
	logic          select_pin_raw, selected_flag_filtered;
	logic          sck_m, sck_s, sck_d;
	logic          mosi_m, mosi_s, miso_m, miso_s;
	logic [7:0]    shreg;
	logic [3:0]    bitcnt;
	logic [2:0]    hcnt;
	logic          sample_bit;
	spicfg_state_t state;

	// -------------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------------
	spicfg_filter u_sel (
		.clk      (clk),
		.reset    (reset),
		.pin      (slave_select_pin),
		.rst_val  (1'b1),
		.synced   (select_pin_raw),
		.filtered (selected_flag_filtered)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			sck_m <= 1'b0;
			sck_s <= 1'b0;
			sck_d <= 1'b0;
		end else begin
			sck_m <= sck_in;
			sck_s <= sck_m;
			sck_d <= sck_s;
		end
	end

	// -------------------------------------------------------------------
	// data pin synchronisers
	// -------------------------------------------------------------------
	// same two-flop depth as the clock path, so a slave sample edge and
	// its data bit leave the synchronisers in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			mosi_m <= 1'b0;
			mosi_s <= 1'b0;
			miso_m <= 1'b0;
			miso_s <= 1'b0;
		end else begin
			mosi_m <= mosi_in;
			mosi_s <= mosi_m;
			miso_m <= miso_in;
			miso_s <= miso_m;
		end
	end

	logic sck_edge, slave_on, lead_edge, m_sample, m_shift, m_done;
	assign slave_on  = !master_select_bit && !selected_flag_filtered;
	assign sck_edge  = slave_on && (sck_s != sck_d);
	// leading edge of a period leaves the idle level
	assign lead_edge = sck_edge && (sck_d == clock_polarity_bit);

	// -------------------------------------------------------------------
	// register port
	// -------------------------------------------------------------------
	logic cfg_wr;
	assign cfg_wr = reg_wr && (reg_addr == CFG_ADDR);

	always_ff @(posedge clk) begin
		if (reset) begin
			master_select_bit  <= RST_MASTER;
			clock_phase_bit    <= RST_PHASE;
			clock_polarity_bit <= RST_POLARITY;
		end else if (cfg_wr && !transfer_busy_flag) begin
			master_select_bit  <= reg_wdata[BIT_MASTER];
			clock_phase_bit    <= reg_wdata[BIT_PHASE];
			clock_polarity_bit <= reg_wdata[BIT_POLARITY];
		end
	end

	// raw bit is the synchronised pin at the read, no filter
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd && reg_addr == CFG_ADDR) begin
			reg_rdata <= {transfer_busy_flag, master_select_bit,
				clock_phase_bit, clock_polarity_bit,
				!selected_flag_filtered,
				select_pin_raw,
				master_select_bit ? 1'b1 : shifter_empty_flag,
				rx_buffer_empty_flag};
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// -------------------------------------------------------------------
	// master clock generator
	// -------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset || !master_select_bit) begin
			state <= SC_IDLE;
			hcnt  <= 3'h0;
		end else begin
			case (state)
				SC_IDLE: begin
					hcnt <= 3'h0;
					if (tx_valid) begin
						state <= SC_FIRST;
					end
				end
				SC_FIRST: begin
					hcnt <= hcnt + 3'h1;
					if (hcnt == 3'(HALF_BIT_CYC - 1)) begin
						hcnt  <= 3'h0;
						state <= SC_SECOND;
					end
				end
				SC_SECOND: begin
					hcnt <= hcnt + 3'h1;
					if (hcnt == 3'(HALF_BIT_CYC - 1)) begin
						hcnt  <= 3'h0;
						state <= (bitcnt == 4'h1) ? SC_IDLE : SC_FIRST;
					end
				end
				default: state <= SC_IDLE;
			endcase
		end
	end

	// sample one clk before the bit period ends
	assign m_sample = master_select_bit && state == SC_SECOND &&
		hcnt == 3'(HALF_BIT_CYC - 2);
	assign m_shift  = master_select_bit && state == SC_SECOND &&
		hcnt == 3'(HALF_BIT_CYC - 1);
	assign m_done   = m_shift && bitcnt == 4'h1;

	// clock rests at polarity; phase 1 toggles at start, phase 0 mid-bit
	always_ff @(posedge clk) begin
		if (reset) begin
			sck_out  <= 1'b0;
			sck_oe_n <= 1'b1;
		end else begin
			sck_oe_n <= !master_select_bit;
			if (state == SC_IDLE) begin
				sck_out <= clock_polarity_bit;
			end else if (clock_phase_bit) begin
				sck_out <= clock_polarity_bit ^ (state == SC_FIRST);
			end else begin
				sck_out <= clock_polarity_bit ^ (state == SC_SECOND);
			end
		end
	end

	// -------------------------------------------------------------------
	// shift engine
	// -------------------------------------------------------------------
	// slave: data centred on first edge for phase 0, second for phase 1,
	// so the sampling edge sits mid-bit
	assign sample_bit = clock_phase_bit ? (sck_edge && !lead_edge) :
		lead_edge;

	logic load, s_done;
	assign load   = tx_valid && !transfer_busy_flag &&
		(master_select_bit ? state == SC_IDLE : slave_on);
	assign s_done = !master_select_bit && sample_bit && bitcnt == 4'h1;

	always_ff @(posedge clk) begin
		if (reset) begin
			shreg  <= 8'h00;
			bitcnt <= 4'h0;
		end else if (load) begin
			shreg  <= tx_data;
			bitcnt <= 4'(BITS_PER_BYTE);
		end else if (m_sample) begin
			shreg <= {shreg[6:0], miso_s};
		end else if (m_shift || (sample_bit && bitcnt != 4'h0)) begin
			if (!master_select_bit) begin
				shreg <= {shreg[6:0], mosi_s};
			end
			bitcnt <= bitcnt - 4'h1;
		end
	end

	assign mosi_out = shreg[7];
	assign miso_out = shreg[7];

	// busy from load to the cycle after the last bit
	always_ff @(posedge clk) begin
		if (reset) begin
			transfer_busy_flag <= 1'b0;
		end else if (load) begin
			transfer_busy_flag <= 1'b1;
		end else if (m_done || s_done || (!master_select_bit && !slave_on)) begin
			transfer_busy_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			tx_taken <= 1'b0;
			rx_new   <= 1'b0;
			rx_data  <= 8'h00;
		end else begin
			tx_taken <= load;
			rx_new   <= m_done || s_done;
			if (m_done) begin
				rx_data <= shreg;
			end else if (s_done) begin
				rx_data <= {shreg[6:0], mosi_s};
			end
		end
	end

	// status flags; shifter-empty set wins over its clear, rx-empty clear wins over rx_read
	always_ff @(posedge clk) begin
		if (reset) begin
			shifter_empty_flag <= RST_SHIFT_MT;
		end else if ((s_done || m_done) && !tx_valid) begin
			shifter_empty_flag <= 1'b1;
		end else if (load || (sck_edge && transfer_busy_flag)) begin
			// the trailing edge after the last bit does not count
			shifter_empty_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rx_buffer_empty_flag <= RST_RX_MT;
		end else if (s_done || m_done) begin
			rx_buffer_empty_flag <= 1'b0;
		end else if (rx_read) begin
			rx_buffer_empty_flag <= 1'b1;
		end
	end
endmodule : spicfg_core

// >>> hw/spicfg_filter.sv
/*
 * spicfg_filter: two-flop synchroniser plus stability filter for one pin.
 * Assumes the pin is asynchronous to clk.
 */
`timescale 1ns/100ps
module spicfg_filter
	import spicfg_pkg::*;
(
	input  wire logic clk,       // system clock
	input  wire logic reset,     // synchronous, active high
	input  wire logic pin,       // asynchronous input
	input  wire logic rst_val,   // level held during reset
	output logic      synced,    // synchronised, unfiltered
	output logic      filtered   // de-glitched level
);
	logic       meta;
	logic [1:0] cnt;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta   <= rst_val;
			synced <= rst_val;
		end else begin
			meta   <= pin;
			synced <= meta;
		end
	end

	// level must hold FILTER_CYC cycles before the output moves
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt      <= 2'h0;
			filtered <= rst_val;
		end else if (synced == filtered) begin
			cnt <= 2'h0;
		end else if (cnt == 2'(FILTER_CYC - 1)) begin
			cnt      <= 2'h0;
			filtered <= synced;
		end else begin
			cnt <= cnt + 2'h1;
		end
	end
endmodule : spicfg_filter

// >>> include/spicfg_pkg.sv
/*
 * spicfg_pkg: constants for the serial port configuration and status block.
 * Assumes a single 20 MHz system clock and a byte-wide special register port.
 */
package spicfg_pkg;
	// register address and bit positions
	localparam logic [7:0] CFG_ADDR      = 8'ha1;
	localparam int         BIT_BUSY      = 7;
	localparam int         BIT_MASTER    = 6;
	localparam int         BIT_PHASE     = 5;
	localparam int         BIT_POLARITY  = 4;
	localparam int         BIT_SELECTED  = 3;
	localparam int         BIT_RAW_SEL   = 2;
	localparam int         BIT_SHIFT_MT  = 1;
	localparam int         BIT_RX_MT     = 0;
	// reset values of the stored control bits and flags
	localparam logic       RST_MASTER    = 1'b0;
	localparam logic       RST_PHASE     = 1'b0;
	localparam logic       RST_POLARITY  = 1'b0;
	localparam logic       RST_SHIFT_MT  = 1'b1;
	localparam logic       RST_RX_MT     = 1'b1;
	// timing
	localparam int         BITS_PER_BYTE = 8;
	localparam int         HALF_BIT_CYC  = 4;   // master half bit, clk cycles
	localparam int         FILTER_CYC    = 3;   // select must be stable this long
endpackage : spicfg_pkg

// >>> verification/spi_config_status_tb_top.sv
/* spi_config_status_tb_top: bench for spicfg_core in both modes.
   assumes a 20 MHz clock and the link clock made here in slave mode. */
`timescale 1ns/100ps
module spi_config_status_tb_top
	import spicfg_pkg::*;
;
	logic       clk = 1'b0;
	logic       reset, wr, rd, tx_valid, rx_read, sck_tb, mosi_tb, c;
	logic       ss_pin, ss_n, taken, rx_new, sck_out, oe_n, pm_miso, s_miso;
	logic [7:0] addr, wdata, rdata, tx_data, rxd, pm_got, pb, tb, d, sb;
	int         err_count, checked, k, i, m;
	wire        sck = oe_n ? sck_tb : sck_out;
	always #25 clk = ~clk;
	spicfg_core dut (.clk(clk), .reset(reset), .reg_addr(addr),
		.reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_taken(taken),
		.rx_data(rxd), .rx_read(rx_read), .rx_new(rx_new),
		.sck_in(sck), .sck_out(sck_out), .sck_oe_n(oe_n),
		.mosi_in(mosi_tb), .mosi_out(), .miso_in(pm_miso), .miso_out(s_miso),
		.slave_select_pin(ss_pin));
	spicfg_slave_model pm (.sck(sck), .ss_n(ss_n), .cpha(c), .tx(pb),
		.mosi(dut.mosi_out), .miso(pm_miso), .got(pm_got));
	// ----
	// shared tasks
	// ----
	function automatic logic [7:0] cfg_exp(input logic [2:0] md);
		return {1'b0, md, 4'h7};
	endfunction : cfg_exp
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk) {addr, wdata, wr} <= {a, v, 1'b1};
		@(posedge clk) wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk) {addr, rd} <= {a, 1'b1};
		@(posedge clk) rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	task complete_run;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	initial begin
		#200000 err_count++;
		complete_run();
	end
	// ----
	// main sequence
	// ----
	initial begin
		{reset, ss_pin, ss_n} = 3'b111;
		{wr, rd, tx_valid, rx_read, sck_tb, mosi_tb, c} = 7'h00;
		{addr, wdata, tx_data, pb} = 32'h0;
		void'($urandom(79));
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		rd_reg(CFG_ADDR, d);
		chk(d, 8'h07);
		rd_reg(8'ha0, d);
		chk(d, 8'h00);
		for (m = 0; m < 4; m++) begin
			c = m[1];
			wr_reg(CFG_ADDR, {2'b11, m[1], m[0], 4'hf});
			rd_reg(CFG_ADDR, d);
			chk(d & 8'hfe, cfg_exp({1'b1, m[1], m[0]}) & 8'hfe);
			chk({6'h0, oe_n, sck_out}, {7'h0, m[0]});
			tb = m[0] ? 8'h00 : 8'($urandom);
			pb = m[1] ? 8'hff : 8'($urandom);
			@(posedge clk) {tx_data, tx_valid, ss_n} <= {tb, 2'b10};
			k = 0;
			while (taken !== 1'b1 && k < 20) begin
				@(posedge clk) #1 k++;
			end
			tx_valid <= 1'b0;
			rd_reg(CFG_ADDR, d);
			chk(d & 8'h80, 8'h80);
			k = 0;
			while (rx_new !== 1'b1 && k < 200) begin
				@(posedge clk) #1 k++;
			end
			chk(rxd, pb);
			@(posedge clk) rx_read <= 1'b1;
			@(posedge clk) rx_read <= 1'b0;
			repeat (6) @(posedge clk);
			chk(pm_got, tb);
			ss_n <= 1'b1;
			rd_reg(CFG_ADDR, d);
			chk(d & 8'h80, 8'h00);
			$display("master test %0d done", m);
		end
		wr_reg(CFG_ADDR, 8'h00);
		ss_pin <= 1'b0;
		repeat (10) @(posedge clk);
		rd_reg(CFG_ADDR, d);
		chk(d, 8'h0b);
		tb = 8'($urandom);
		sb = 8'($urandom);
		@(posedge clk) {tx_data, tx_valid} <= {sb, 1'b1};
		repeat (2) @(posedge clk);
		tx_valid <= 1'b0;
		#37;
		for (i = 7; i >= 0; i--) begin
			mosi_tb = tb[i];
			#200 pb = {pb[6:0], s_miso};
			sck_tb = 1'b1;
			if (i == 3) begin
				rd_reg(CFG_ADDR, d);
				chk(d & 8'h82, 8'h80);
			end
			#200 sck_tb = 1'b0;
		end
		repeat (10) @(posedge clk);
		chk(rxd, tb);
		chk(pb, sb);
		rd_reg(CFG_ADDR, d);
		chk(d, 8'h0a);
		@(posedge clk) rx_read <= 1'b1;
		@(posedge clk) rx_read <= 1'b0;
		rd_reg(CFG_ADDR, d);
		chk(d, 8'h0b);
		$display("slave test done");
		complete_run();
	end
endmodule : spi_config_status_tb_top

// >>> verification/spicfg_core_asserts.sv
/* spicfg_core_asserts: port checks for spicfg_core.
   assumes HALF_BIT_CYC of 4 and no read right after a mode write. */
`timescale 1ns/100ps
module spicfg_core_chk
	import spicfg_pkg::*;
(
	input wire logic       clk,              // clock
	input wire logic       reset,            // sync reset
	input wire logic [7:0] reg_addr,         // address
	input wire logic       reg_wr,           // write
	input wire logic       reg_rd,           // read
	input wire logic [7:0] reg_rdata,        // read data
	input wire logic       tx_taken,         // load seen
	input wire logic       rx_new,           // byte done
	input wire logic       sck_out,          // clock out
	input wire logic       sck_oe_n,         // clock enable
	input wire logic       slave_select_pin  // select pin
);
	// ----
	// clock toggles since load, 16 means idle
	// ----
	logic [4:0] n;
	logic       q;
	wire        rd = reg_rd && reg_addr == CFG_ADDR;
	always_ff @(posedge clk) begin
		q <= sck_out;
		if (reset)
			n <= 5'h10;
		else if (tx_taken)
			n <= (q != sck_out) ? 5'h01 : 5'h00;
		else if (q != sck_out && n != 5'h10)
			n <= n + 5'h01;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	AST_SCK_HALF: assert property (!sck_oe_n && n != 5'h10 && $changed(sck_out)
		|=> $stable(sck_out) [*3]) else $error("sck half too short");
	AST_SCK_IDLE: assert property (n == 5'h10 && !sck_oe_n && !$past(reg_wr)
		&& !$past(reg_wr, 2) && !tx_taken |-> $stable(sck_out))
		else $error("idle sck moved");
	AST_EDGES: assert property (rx_new && !sck_oe_n |-> ##2 n == 5'h10)
		else $error("not 16 sck edges");
	AST_RAW_SEL: assert property ($stable(slave_select_pin) [*4] ##0 rd
		|=> reg_rdata[BIT_RAW_SEL] == $past(slave_select_pin))
		else $error("raw select wrong");
	AST_SELECTED: assert property ($stable(slave_select_pin) [*8] ##0 rd
		|=> reg_rdata[BIT_SELECTED] != $past(slave_select_pin))
		else $error("selected flag wrong");
	AST_MASTER: assert property (rd && !sck_oe_n |=> reg_rdata[BIT_MASTER]
		&& reg_rdata[BIT_SHIFT_MT]) else $error("master bits wrong");
	AST_BUSY_ON: assert property (rd && !sck_oe_n && n < 5'h0f
		|=> reg_rdata[BIT_BUSY]) else $error("busy low in transfer");
	AST_BUSY_OFF: assert property (rd && !sck_oe_n && n == 5'h10
		&& $past(n, 4) == 5'h10 |=> !reg_rdata[BIT_BUSY])
		else $error("busy high when idle");
	AST_CV_MDONE: cover property (rx_new && !sck_oe_n);
	AST_CV_SDONE: cover property (rx_new && sck_oe_n);
	AST_CV_BUSY: cover property (rd && n < 5'h0f);
endmodule : spicfg_core_chk

bind spicfg_core spicfg_core_chk chk (.clk, .reset, .reg_addr, .reg_wr,
	.reg_rd, .reg_rdata, .tx_taken, .rx_new, .sck_out, .sck_oe_n,
	.slave_select_pin);

// >>> verification/spicfg_slave_model.sv
/* spicfg_slave_model: far-side serial slave for master transfers.
   assumes the clock idles between frames and select frames each byte. */
`timescale 1ns/100ps
module spicfg_slave_model (
	input  wire logic       sck,   // serial clock wire
	input  wire logic       ss_n,  // select, active low
	input  wire logic       cpha,  // phase in use
	input  wire logic [7:0] tx,    // byte to send
	input  wire logic       mosi,  // data from master
	output logic            miso,  // data to master
	output logic      [7:0] got    // byte received
);
	int e;
	initial miso = 1'b0;
	always @(negedge ss_n) begin
		e = 0;
		miso = tx[7];
	end
	// no pull on the line, so a released line shows the inverse
	always @(posedge ss_n)
		miso = ~miso;
	// edges counted from the idle level, whichever it is
	always @(sck) if (!ss_n && e < 16) begin
		e = e + 1;
		if (e[0] != cpha)
			got = {got[6:0], mosi};
		else if (e < 16)
			miso = tx[7 - (e >> 1)];
	end
endmodule : spicfg_slave_model
